/* rcafb_core.v */
// rcafb: channel assessment, link quality, frame filter, frame store, dual network
`timescale 1ns/1ns
`include "rcafb_regs.vh"

module rcafb_core #(
    parameter ED_CYC = `RCAFB_ED_CYC,
    parameter LQI_CYC = `RCAFB_LQI_CYC,
    parameter US_DIV = `RCAFB_US_DIV
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // host byte access, already synchronised by the serial front end
    input wire acc_start,
    input wire acc_buf,
    input wire [6:0] acc_addr,
    input wire acc_wr,
    input wire [7:0] acc_wdata,
    input wire acc_rd,
    output reg [7:0] acc_rdata,
    output reg acc_rvalid,
    // channel assessment
    input wire cca_req,
    input wire rx_ready,
    output wire rx_on,
    output reg cca_done,
    output reg cca_busy,
    // demodulator side
    input wire [7:0] rssi,
    input wire [7:0] corr_peak,
    input wire sig_detect,
    input wire preamble_det,
    input wire rx_start,
    input wire rx_byte_vld,
    input wire [7:0] rx_byte,
    input wire rx_end,
    input wire fcs_ok,
    // filter and acknowledge
    output reg frame_accept,
    output reg ack_req,
    output reg [7:0] ack_seq,
    output reg ack_pending,
    // under-run interrupt
    output wire underrun_irq,
    // dual network
    output wire active_net,
    output wire [7:0] chan_int,
    output wire [15:0] chan_frac
);

    localparam [19:0] ED_DIV = ED_CYC;
    localparam [11:0] ED_LAST = ED_CYC - 1;
    localparam [18:0] LQI_DIV = LQI_CYC;
    localparam [11:0] LQI_LAST = LQI_CYC - 1;
    localparam [4:0] US_LAST = US_DIV - 1;
    // assessment states, one-hot
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_WARM = 3'b010;
    localparam [2:0] S_MEAS = 3'b100;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] ctrl_reg;          // mode, combine, lqi source, lock, ...
    reg [7:0] dual_reg;          // dual enable, manual set, coordinator roles
    reg [7:0] thr_reg;           // energy threshold
    reg [7:0] ed_reg;            // last energy result
    reg [7:0] lqi_reg;           // final link quality
    reg [7:0] lqi_cont_reg;      // continuously updated link quality
    reg [7:0] rx_len_reg;        // received frame length
    reg [255:0] cfg_reg;         // timer, addresses, channels as bytes
    reg underrun_reg;            // sticky under-run
    reg [7:0] mem [0:`RCAFB_STORE_BYTES-1]; // shared frame store
    reg [6:0] ptr_reg;           // host access pointer
    reg tgt_buf_reg;             // pointer targets the frame store

    wire [1:0] cca_mode = ctrl_reg[`RCAFB_CTRL_MODE +: 2];
    wire prom = ctrl_reg[`RCAFB_CTRL_PROM];
    wire lock = ctrl_reg[`RCAFB_CTRL_LOCK];
    wire net = active_net;
    // shared timer period, then the fields of the selected parameter set
    wire [15:0] tmr_period = cfg_reg[`RCAFB_F(`RCAFB_TMR_OFS) +: 16];
    wire [15:0] pan_id = net ? cfg_reg[`RCAFB_F(`RCAFB_NETWORK_SET_ONE_OFS) +: 16]
                             : cfg_reg[`RCAFB_F(`RCAFB_NETWORK_SET_ZERO_OFS) +: 16];
    wire [15:0] short_addr = net ? cfg_reg[`RCAFB_F(`RCAFB_SHORT1_OFS) +: 16]
                                 : cfg_reg[`RCAFB_F(`RCAFB_SHORT0_OFS) +: 16];
    wire [63:0] long_addr = net ? cfg_reg[`RCAFB_F(`RCAFB_LONG1_OFS) +: 64]
                                : cfg_reg[`RCAFB_F(`RCAFB_LONG0_OFS) +: 64];
    wire coord = net ? dual_reg[`RCAFB_DUAL_CRD1] : dual_reg[`RCAFB_DUAL_CRD0];
    assign chan_int = net ? cfg_reg[`RCAFB_F(`RCAFB_CHI1_OFS) +: 8]
                          : cfg_reg[`RCAFB_F(`RCAFB_CHI0_OFS) +: 8];
    assign chan_frac = net ? cfg_reg[`RCAFB_F(`RCAFB_CHF1_OFS) +: 16]
                           : cfg_reg[`RCAFB_F(`RCAFB_CHF0_OFS) +: 16];

    ////////////////////////////////////////////////////////////////////////////
    // receive parsing state
    reg rx_busy_reg;             // between frame start and end
    reg [7:0] idx_reg;           // index of next received byte
    reg [15:0] fcf_reg;          // frame control field
    reg [15:0] dpan_reg;         // destination network id
    reg [63:0] daddr_reg;        // destination address, little-endian fill
    reg [7:0] cmd_reg;           // first payload byte
    reg [7:0] seq_reg;           // sequence byte of the frame in progress

    wire [1:0] dm = fcf_reg[11:10];
    wire [1:0] sm = fcf_reg[15:14];
    wire [2:0] ftype = fcf_reg[2:0];
    wire [7:0] dlen = (dm == 2'd3) ? 8'h08 : ((dm == 2'd2) ? 8'h02 : 8'h00);
    wire [7:0] slen = (sm == 2'd3) ? 8'h08 : ((sm == 2'd2) ? 8'h02 : 8'h00);
    wire [7:0] dhdr = (dm != 2'd0) ? (8'h02 + dlen) : 8'h00;
    wire [7:0] shdr = (sm != 2'd0) ? ((fcf_reg[6] ? 8'h00 : 8'h02) + slen) : 8'h00;
    wire [7:0] cmd_pos = 8'h04 + dhdr + shdr;
    wire [7:0] daddr_end = 8'h06 + dlen;

    // address and role checks against the active set
    wire pan_ok = (dpan_reg == pan_id) || (dpan_reg == 16'hFFFF);
    wire dst_ok = (dm == 2'd2) ? ((daddr_reg[63:48] == short_addr) ||
                                  (daddr_reg[63:48] == 16'hFFFF))
                               : (daddr_reg == long_addr);
    wire noaddr_ok = (ftype == `RCAFB_FT_BEACON) ||
                     (coord && ((ftype == `RCAFB_FT_DATA) || (ftype == `RCAFB_FT_CMD)));
    wire addr_ok = (dm == 2'd0) ? noaddr_ok : ((dm != 2'd1) && pan_ok && dst_ok);
    wire len_ok = (rx_len_reg >= `RCAFB_MIN_LEN) && (rx_len_reg <= `RCAFB_MAX_LEN);
    wire pass = fcs_ok && len_ok && (prom || addr_ok);
    wire data_poll = (ftype == `RCAFB_FT_CMD) && (cmd_reg == `RCAFB_CMD_DATA_REQ);

    ////////////////////////////////////////////////////////////////////////////
    // frame store write port selection
    wire host_buf_wr = acc_wr && tgt_buf_reg;
    wire [7:0] lqi_addr = rx_len_reg + 8'h01;
    wire rx_data_we = rx_byte_vld && rx_busy_reg && !lock &&
                      (idx_reg != 8'h00) && !idx_reg[7];
    // lqi byte after last frame byte, dropped if it would overflow
    wire rx_lqi_we = rx_end && rx_busy_reg && !lock && !lqi_addr[7];

    // host has priority; a same-cycle receive byte is dropped
    // single shared store
    always @(posedge ref_clk) begin
        if (host_buf_wr) begin
            mem[ptr_reg] <= acc_wdata;
        end else if (rx_data_we) begin
            mem[idx_reg[6:0]] <= rx_byte;
        end else if (rx_lqi_we) begin
            mem[lqi_addr[6:0]] <= lqi_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host pointer, register writes, sticky under-run
    wire [6:0] cfg_idx = ptr_reg - `RCAFB_CFG_BASE;
    wire reg_wr = acc_wr && !tgt_buf_reg;
    wire stat_rd = acc_rd && !tgt_buf_reg && (ptr_reg == `RCAFB_STAT_OFS);
    // reading ahead of the receive writer is an under-run
    wire underrun_ev = acc_rd && tgt_buf_reg && rx_busy_reg &&
                       ({1'b0, ptr_reg} >= idx_reg);

    always @(posedge ref_clk) begin
        if (!nrst) begin
            ptr_reg <= 7'h00;
            tgt_buf_reg <= 1'b0;
            ctrl_reg <= `RCAFB_CTRL_RST;
            dual_reg <= `RCAFB_DUAL_RST;
            thr_reg <= `RCAFB_THR_RST;
            cfg_reg <= 256'h0;
            underrun_reg <= 1'b0;
        end else begin
            // start loads pointer, each access advances it
            if (acc_start) begin
                ptr_reg <= acc_addr;
                tgt_buf_reg <= acc_buf;
            end else if (acc_wr || acc_rd) begin
                ptr_reg <= ptr_reg + 7'h01;
            end
            // writable registers; read-only ones ignore writes
            if (reg_wr) begin
                if (ptr_reg == `RCAFB_CTRL_OFS) begin
                    ctrl_reg <= acc_wdata;
                end else if (ptr_reg == `RCAFB_DUAL_OFS) begin
                    dual_reg <= acc_wdata;
                end else if (ptr_reg == `RCAFB_THR_OFS) begin
                    thr_reg <= acc_wdata;
                end else if ((ptr_reg >= `RCAFB_CFG_BASE) && (ptr_reg <= `RCAFB_CFG_LAST)) begin
                    cfg_reg[8 * cfg_idx[4:0] +: 8] <= acc_wdata;
                end
            end
            if (underrun_ev) begin
                underrun_reg <= 1'b1;
            end else if (stat_rd) begin
                underrun_reg <= 1'b0;
            end
        end
    end
    assign underrun_irq = underrun_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read data mux, registered one cycle after the read strobe
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (tgt_buf_reg) begin
            rd_mux = mem[ptr_reg];
        end else if (ptr_reg == `RCAFB_CTRL_OFS) begin
            rd_mux = ctrl_reg;
        end else if (ptr_reg == `RCAFB_DUAL_OFS) begin
            rd_mux = dual_reg;
        end else if (ptr_reg == `RCAFB_STAT_OFS) begin
            rd_mux = {4'h0, rx_busy_reg, underrun_reg, cca_busy, active_net};
        end else if (ptr_reg == `RCAFB_THR_OFS) begin
            rd_mux = thr_reg;
        end else if (ptr_reg == `RCAFB_ED_OFS) begin
            rd_mux = ed_reg;
        end else if (ptr_reg == `RCAFB_LQI_OFS) begin
            rd_mux = lqi_reg;
        end else if (ptr_reg == `RCAFB_LQIC_OFS) begin
            rd_mux = lqi_cont_reg;
        end else if (ptr_reg == `RCAFB_RXLEN_OFS) begin
            rd_mux = rx_len_reg;
        end else if (ptr_reg <= `RCAFB_CFG_LAST) begin
            rd_mux = cfg_reg[8 * cfg_idx[4:0] +: 8];
        end
    end

    always @(posedge ref_clk) begin
        if (!nrst) begin
            acc_rdata <= 8'h00;
            acc_rvalid <= 1'b0;
        end else begin
            acc_rvalid <= acc_rd;
            if (acc_rd) begin
                acc_rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear channel assessment and energy detection
    reg [2:0] cca_st;
    reg [11:0] ed_cnt;
    reg [19:0] ed_sum;
    reg sig_seen;
    wire [19:0] ed_sum_next = ed_sum + {12'h000, rssi};
    wire [19:0] ed_mean = ed_sum_next / ED_DIV;
    wire busy1 = ed_mean[7:0] > thr_reg;
    wire busy2 = sig_seen || sig_detect;
    wire busy3 = ctrl_reg[`RCAFB_CTRL_OR] ? (busy1 || busy2) : (busy1 && busy2);
    assign rx_on = (cca_st != S_IDLE);

    always @(posedge ref_clk) begin
        if (!nrst) begin
            cca_st <= S_IDLE;
            ed_cnt <= 12'h000;
            ed_sum <= 20'h00000;
            sig_seen <= 1'b0;
            ed_reg <= 8'h00;
            cca_done <= 1'b0;
            cca_busy <= 1'b0;
        end else begin
            cca_done <= 1'b0;
            case (cca_st)
                S_IDLE: begin
                    // request first warms the receiver up
                    if (cca_req) begin
                        cca_st <= S_WARM;
                    end
                end
                S_WARM: begin
                    ed_cnt <= 12'h000;
                    ed_sum <= 20'h00000;
                    sig_seen <= 1'b0;
                    if (rx_ready) begin
                        cca_st <= S_MEAS;
                    end
                end
                S_MEAS: begin
                    ed_sum <= ed_sum_next;
                    ed_cnt <= ed_cnt + 12'h001;
                    if (sig_detect) begin
                        sig_seen <= 1'b1;
                    end
                    if (ed_cnt == ED_LAST) begin
                        ed_reg <= ed_mean[7:0];
                        cca_done <= 1'b1;
                        cca_st <= S_IDLE;
                        if (cca_mode == 2'd2) begin
                            cca_busy <= busy2;
                        end else if (cca_mode == 2'd3) begin
                            cca_busy <= busy3;
                        end else begin
                            cca_busy <= busy1;
                        end
                    end
                end
                default: begin
                    cca_st <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link quality
    reg lqi_run;
    reg [11:0] lqi_cnt;
    reg [18:0] lqi_sum;
    reg [7:0] lqi_max;
    wire [18:0] lqi_sum_next = lqi_sum + {11'h000, rssi};
    wire [18:0] lqi_mean = lqi_sum_next / LQI_DIV;
    wire [7:0] lqi_max_next = (corr_peak > lqi_max) ? corr_peak : lqi_max;

    always @(posedge ref_clk) begin
        if (!nrst) begin
            lqi_run <= 1'b0;
            lqi_cnt <= 12'h000;
            lqi_sum <= 19'h00000;
            lqi_max <= 8'h00;
            lqi_reg <= 8'h00;
            lqi_cont_reg <= 8'h00;
        end else begin
            if (preamble_det) begin
                lqi_run <= 1'b1;
                lqi_cnt <= 12'h000;
                lqi_sum <= 19'h00000;
                lqi_max <= 8'h00;
            end else if (lqi_run) begin
                lqi_sum <= lqi_sum_next;
                lqi_max <= lqi_max_next;
                lqi_cnt <= lqi_cnt + 12'h001;
                // final value after the fixed delay
                if (lqi_cnt == LQI_LAST) begin
                    lqi_run <= 1'b0;
                    lqi_reg <= ctrl_reg[`RCAFB_CTRL_CORR] ? lqi_max_next : lqi_mean[7:0];
                end
            end
            // refresh from rssi through the frame
            if (ctrl_reg[`RCAFB_CTRL_CONT] && rx_busy_reg) begin
                lqi_cont_reg <= rssi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame parsing, filtering and acknowledge request
    always @(posedge ref_clk) begin
        if (!nrst) begin
            rx_busy_reg <= 1'b0;
            idx_reg <= 8'h00;
            rx_len_reg <= 8'h00;
            fcf_reg <= 16'h0000;
            dpan_reg <= 16'h0000;
            daddr_reg <= 64'h0;
            cmd_reg <= 8'h00;
            seq_reg <= 8'h00;
            frame_accept <= 1'b0;
            ack_req <= 1'b0;
            ack_seq <= 8'h00;
            ack_pending <= 1'b0;
        end else begin
            frame_accept <= 1'b0;
            ack_req <= 1'b0;
            if (rx_start) begin
                rx_busy_reg <= 1'b1;
                idx_reg <= 8'h00;
            end else if (rx_end && rx_busy_reg) begin
                rx_busy_reg <= 1'b0;
                frame_accept <= pass;
                if (pass && !prom && fcf_reg[5]) begin
                    ack_req <= 1'b1;
                    // sequence moves only with its request, never mid-frame
                    ack_seq <= seq_reg;
                    ack_pending <= data_poll && ctrl_reg[`RCAFB_CTRL_PEND];
                end
            end else if (rx_byte_vld && rx_busy_reg) begin
                idx_reg <= idx_reg + 8'h01;
                // length goes to its own register
                if (idx_reg == 8'h00) begin
                    rx_len_reg <= rx_byte;
                end else if (idx_reg == 8'h01) begin
                    fcf_reg[7:0] <= rx_byte;
                end else if (idx_reg == 8'h02) begin
                    fcf_reg[15:8] <= rx_byte;
                end else if (idx_reg == 8'h03) begin
                    seq_reg <= rx_byte;
                end else if (idx_reg == 8'h04) begin
                    dpan_reg[7:0] <= rx_byte;
                end else if (idx_reg == 8'h05) begin
                    dpan_reg[15:8] <= rx_byte;
                end else if (idx_reg < daddr_end) begin
                    daddr_reg <= {rx_byte, daddr_reg[63:8]};
                end
                if (idx_reg == cmd_pos) begin
                    cmd_reg <= rx_byte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dual network switching on a microsecond tick
    reg [4:0] us_cnt;
    reg [15:0] tmr_cnt;
    reg net_reg;
    wire us_tick = (us_cnt == US_LAST);
    assign active_net = net_reg;

    always @(posedge ref_clk) begin
        if (!nrst) begin
            us_cnt <= 5'h00;
            tmr_cnt <= 16'h0000;
            net_reg <= 1'b0;
        end else begin
            us_cnt <= us_tick ? 5'h00 : (us_cnt + 5'h01);
            // timer alternates the sets when enabled
            if (!dual_reg[`RCAFB_DUAL_EN]) begin
                net_reg <= dual_reg[`RCAFB_DUAL_SEL];
                tmr_cnt <= 16'h0000;
            end else if (us_tick) begin
                if ((tmr_cnt + 16'h0001) >= tmr_period) begin
                    tmr_cnt <= 16'h0000;
                    net_reg <= !net_reg;
                end else begin
                    tmr_cnt <= tmr_cnt + 16'h0001;
                end
            end
        end
    end

endmodule

/* rcafb_regs.vh */
// rcafb register offsets, field positions, reset values and timing counts
`ifndef RCAFB_REGS_VH
`define RCAFB_REGS_VH

// clock and timing
`define RCAFB_CLK_MHZ 25
`define RCAFB_ED_WIN_US 128
`define RCAFB_ED_CYC (`RCAFB_ED_WIN_US * `RCAFB_CLK_MHZ)
`define RCAFB_LQI_DLY_US 64
`define RCAFB_LQI_CYC (`RCAFB_LQI_DLY_US * `RCAFB_CLK_MHZ)
`define RCAFB_US_DIV `RCAFB_CLK_MHZ

// frame store and frame limits
`define RCAFB_STORE_BYTES 128
`define RCAFB_MIN_LEN 8'h05
`define RCAFB_MAX_LEN 8'h7F
`define RCAFB_CMD_DATA_REQ 8'h04
`define RCAFB_FT_BEACON 3'h0
`define RCAFB_FT_DATA 3'h1
`define RCAFB_FT_CMD 3'h3

// register offsets
`define RCAFB_CTRL_OFS 7'h00
`define RCAFB_DUAL_OFS 7'h01
`define RCAFB_STAT_OFS 7'h02
`define RCAFB_THR_OFS 7'h03
`define RCAFB_ED_OFS 7'h04
`define RCAFB_LQI_OFS 7'h05
`define RCAFB_LQIC_OFS 7'h06
`define RCAFB_RXLEN_OFS 7'h07
`define RCAFB_CFG_BASE 7'h08
`define RCAFB_TMR_OFS 7'h08
`define RCAFB_NETWORK_SET_ZERO_OFS 7'h0A
`define RCAFB_NETWORK_SET_ONE_OFS 7'h0C
`define RCAFB_SHORT0_OFS 7'h0E
`define RCAFB_SHORT1_OFS 7'h10
`define RCAFB_LONG0_OFS 7'h12
`define RCAFB_LONG1_OFS 7'h1A
`define RCAFB_CHI0_OFS 7'h22
`define RCAFB_CHF0_OFS 7'h23
`define RCAFB_CHI1_OFS 7'h25
`define RCAFB_CHF1_OFS 7'h26
`define RCAFB_CFG_LAST 7'h27
`define RCAFB_F(ofs) (8 * ((ofs) - `RCAFB_CFG_BASE))

// control register fields
`define RCAFB_CTRL_MODE 0
`define RCAFB_CTRL_OR 2
`define RCAFB_CTRL_CORR 3
`define RCAFB_CTRL_CONT 4
`define RCAFB_CTRL_PROM 5
`define RCAFB_CTRL_LOCK 6
`define RCAFB_CTRL_PEND 7
// dual register fields
`define RCAFB_DUAL_EN 0
`define RCAFB_DUAL_SEL 1
`define RCAFB_DUAL_CRD0 2
`define RCAFB_DUAL_CRD1 3

// reset values
`define RCAFB_CTRL_RST 8'h01
`define RCAFB_DUAL_RST 8'h00
`define RCAFB_THR_RST 8'h80

`endif

/* rcafb_core_monitor.sv */
// concurrent checks on the rcafb core ports
`timescale 1ns/1ns
module rcafb_core_chk (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // watched ports
    input wire acc_rd,
    input wire acc_rvalid,
    input wire rx_on,
    input wire cca_done,
    input wire rx_end,
    input wire frame_accept,
    input wire ack_req,
    input wire [7:0] ack_seq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_rd_ans; acc_rd |=> acc_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read gave no data");
    property p_rv_cause; acc_rvalid |-> $past(acc_rd); endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("data without read");
    property p_cca_warm; cca_done |-> $past(rx_on); endproperty
    a_cca_warm: assert property (p_cca_warm) else $error("assessed while off");
    property p_cca_off; cca_done |-> !rx_on; endproperty
    a_cca_off: assert property (p_cca_off) else $error("receiver left on");
    property p_done_pulse; cca_done |=> !cca_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_ack_acc; ack_req |-> frame_accept; endproperty
    a_ack_acc: assert property (p_ack_acc) else $error("ack for dropped frame");
    property p_acc_end; frame_accept |-> $past(rx_end); endproperty
    a_acc_end: assert property (p_acc_end) else $error("accept not after end");
    // a second reset clears the sequence, so its first edge is left out
    property p_seq; $changed(ack_seq) && $past(nrst) |-> ack_req; endproperty
    a_seq: assert property (p_seq) else $error("sequence moved alone");
    c_cca: cover property (cca_done);
    c_acc: cover property (frame_accept);
    c_ack: cover property (ack_req);
endmodule
bind rcafb_core rcafb_core_chk chk (.ref_clk, .nrst, .acc_rd, .acc_rvalid, .rx_on, .cca_done,
    .rx_end, .frame_accept, .ack_req, .ack_seq);

/* rcafb_host_model.sv */
// host model driving the synchronised byte access port
`timescale 1ns/1ns
module rcafb_host_model (
    // clock
    input wire ref_clk,
    // byte access towards the core
    output reg acc_start = 1'b0,
    output reg acc_buf = 1'b0,
    output reg [6:0] acc_addr = 7'h00,
    output reg acc_wr = 1'b0,
    output reg [7:0] acc_wdata = 8'h00,
    output reg acc_rd = 1'b0,
    input wire [7:0] acc_rdata,
    input wire acc_rvalid
);
    task open(input b, input [6:0] a);
        begin
            @(posedge ref_clk);
            #2 acc_start = 1;
            acc_buf = b;
            acc_addr = a;
            @(posedge ref_clk);
            #2 acc_start = 0;
            acc_addr = ~a;
        end
    endtask
    // released data is inverted so stale values never look right
    task wr(input [7:0] d);
        begin
            @(posedge ref_clk);
            #2 acc_wr = 1;
            acc_wdata = d;
            @(posedge ref_clk);
            #2 acc_wr = 0;
            acc_wdata = ~d;
        end
    endtask
    // data is taken only while the valid pulse stands
    task rd(output [7:0] d);
        begin
            @(posedge ref_clk);
            #2 acc_rd = 1;
            @(posedge ref_clk);
            #2 acc_rd = 0;
            d = (acc_rvalid === 1'b1) ? acc_rdata : 8'hXX;
        end
    endtask
endmodule

/* rcafb_core_test.sv */
// self-checking bench for the rcafb core
`timescale 1ns/1ns
module rcafb_core_test;
    reg ref_clk = 0, nrst = 0, cca_req = 0, rx_ready = 0, sig_detect = 0, preamble_det = 0;
    reg rx_start = 0, rx_byte_vld = 0, rx_end = 0, fcs_ok = 0;
    reg [7:0] rssi = 8'h00, corr_peak = 8'h00, rx_byte = 8'h00, v;
    wire acc_start, acc_buf, acc_wr, acc_rd, acc_rvalid, rx_on, cca_done, cca_busy;
    wire frame_accept, ack_req, ack_pending, underrun_irq, active_net;
    wire [6:0] acc_addr;
    wire [7:0] acc_wdata, acc_rdata, ack_seq, chan_int;
    integer miscompares = 0, checked = 0, cyc = 0, i;
    rcafb_host_model h (.ref_clk, .acc_start, .acc_buf, .acc_addr, .acc_wr, .acc_wdata, .acc_rd,
        .acc_rdata, .acc_rvalid);
    rcafb_core #(.ED_CYC(8), .LQI_CYC(6), .US_DIV(4)) dut (.ref_clk, .nrst, .acc_start, .acc_buf,
        .acc_addr, .acc_wr, .acc_wdata, .acc_rd, .acc_rdata, .acc_rvalid, .cca_req, .rx_ready,
        .rx_on, .cca_done, .cca_busy, .rssi, .corr_peak, .sig_detect, .preamble_det,
        .rx_start, .rx_byte_vld, .rx_byte, .rx_end, .fcs_ok, .frame_accept, .ack_req, .ack_seq,
        .ack_pending, .underrun_irq, .active_net, .chan_int, .chan_frac());
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task cmp(input string nm, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("ERROR %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wreg(input [6:0] a, input [7:0] d);
        begin
            h.open(1'b0, a);
            h.wr(d);
        end
    endtask
    task rchk(input b, input [6:0] a, input [7:0] e, input string nm);
        begin
            h.open(b, a);
            h.rd(v);
            cmp(nm, e, v);
        end
    endtask
    task burst(input b, input [6:0] a);
        begin
            h.open(b, a);
            for (i = 0; i < 4; i = i + 1) h.wr(8'hA0 + i[7:0]);
            h.open(b, a);
            for (i = 0; i < 4; i = i + 1) begin
                h.rd(v);
                cmp("burst", 8'hA0 + i[7:0], v);
            end
        end
    endtask
    task cca(input [7:0] c, input [7:0] r, input s, input e);
        begin
            wreg(7'h00, c);
            rssi = r;
            sig_detect = s;
            @(posedge ref_clk);
            #2 cca_req = 1;
            @(posedge ref_clk);
            #2 cca_req = 0;
            cmp("rx_on", 8'h01, {7'h00, rx_on});
            rx_ready = 1;
            i = 0;
            while (cca_done !== 1'b1 && i < 40) begin
                @(posedge ref_clk);
                #2 i = i + 1;
            end
            rx_ready = 0;
            cmp("done", 8'h01, {7'h00, cca_done});
            cmp("busy", {7'h00, e}, {7'h00, cca_busy});
            rchk(1'b0, 7'h04, r, "energy");
        end
    endtask
    // frame bytes go out low byte first, length byte leading
    task rx_frame(input [79:0] f, input integer n, input a);
        begin
            @(posedge ref_clk);
            #2 preamble_det = 1;
            @(posedge ref_clk);
            #2 preamble_det = 0;
            rx_start = 1;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge ref_clk);
                #2 rx_start = 0;
                rx_byte_vld = 1;
                rx_byte = f[8*i +: 8];
            end
            @(posedge ref_clk);
            #2 rx_byte_vld = 0;
            rx_end = 1;
            fcs_ok = 1;
            @(posedge ref_clk);
            #2 rx_end = 0;
            cmp("accept", 8'h01, {7'h00, frame_accept});
            cmp("ack", {7'h00, a}, {7'h00, ack_req});
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // a hang is cut short well beyond the expected run length
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        #2 nrst = 1;
        rchk(1'b0, 7'h00, 8'h01, "ctrl");
        rchk(1'b0, 7'h01, 8'h00, "dual");
        rchk(1'b0, 7'h03, 8'h80, "thr");
        rchk(1'b0, 7'h30, 8'h00, "unmapped");
        burst(1'b0, 7'h0A);
        burst(1'b1, 7'h7E);
        cca(8'h01, 8'hC0, 1'b0, 1'b1);
        cca(8'h01, 8'h20, 1'b1, 1'b0);
        cca(8'h02, 8'h20, 1'b1, 1'b1);
        cca(8'h02, 8'hC0, 1'b0, 1'b0);
        cca(8'h03, 8'hC0, 1'b0, 1'b0);
        cca(8'h07, 8'hC0, 1'b0, 1'b1);
        wreg(7'h00, 8'h00);
        wreg(7'h01, 8'h04);
        rssi = 8'h3C;
        rx_frame(80'hEEEE5678A1A05A802109, 10, 1'b1);
        cmp("ack_seq", 8'h5A, ack_seq);
        cmp("no_pend", 8'h00, {7'h00, ack_pending});
        // data poll command with pending enabled, link quality from correlator
        corr_peak = 8'h6A;
        wreg(7'h00, 8'h88);
        rx_frame(80'h00000477002306, 7, 1'b1);
        cmp("pending", 8'h01, {7'h00, ack_pending});
        rchk(1'b1, 7'h07, 8'h6A, "corr_lqi");
        wreg(7'h00, 8'h30);
        rx_frame(80'h555453525105, 6, 1'b0);
        rchk(1'b0, 7'h07, 8'h05, "rx_len");
        rchk(1'b1, 7'h01, 8'h51, "store");
        rchk(1'b1, 7'h06, 8'h3C, "lqi_byte");
        rchk(1'b0, 7'h05, 8'h3C, "lqi");
        rchk(1'b0, 7'h06, 8'h3C, "lqi_cont");
        wreg(7'h00, 8'h60);
        rx_frame(80'h757473727105, 6, 1'b0);
        rchk(1'b1, 7'h01, 8'h51, "locked");
        h.open(1'b1, 7'h00);
        h.wr(8'h02);
        h.wr(8'h99);
        rchk(1'b1, 7'h00, 8'h02, "tx_len");
        rchk(1'b1, 7'h01, 8'h99, "host_load");
        // a store read while a frame is under way runs ahead of the writer
        @(posedge ref_clk);
        #2 rx_start = 1;
        @(posedge ref_clk);
        #2 rx_start = 0;
        rchk(1'b1, 7'h05, 8'h55, "ahead");
        cmp("underrun", 8'h01, {7'h00, underrun_irq});
        rchk(1'b0, 7'h02, 8'h0E, "status");
        cmp("cleared", 8'h00, {7'h00, underrun_irq});
        // a two tick timer swaps the set and its channel
        wreg(7'h25, 8'h0B);
        wreg(7'h08, 8'h02);
        wreg(7'h01, 8'h01);
        i = 0;
        while (active_net !== 1'b1 && i < 20) begin
            @(posedge ref_clk);
            #2 i = i + 1;
        end
        cmp("chan1", 8'h0B, chan_int);
        repeat (7) @(posedge ref_clk);
        #2 cmp("net1", 8'h01, {7'h00, active_net});
        @(posedge ref_clk);
        #2 cmp("net0", 8'h00, {7'h00, active_net});
        cmp("chan0", 8'h00, chan_int);
        end_sim;
    end
endmodule
